// ---- core/exit_info_save.sv ----
// Exit information capture and guest state save with register read-back
// Notes on behaviour
// RULE_01: Delivery-time exit sets valid bit, saves event
// RULE_02: Direct, double-fault, fetch, triple exits excluded
// RULE_03: Task-gate exit only after initial checks pass
// RULE_04: Other exits clear vectoring valid bit 31
// RULE_05: Error code saved when valid and bit11
// RULE_06: Fault-like instruction exits record length 1-15
// RULE_07: Software exceptions and task switches record length
// RULE_08: Trap after control register 8 skips length
// RULE_09: Status-word load saves operand linear address
// RULE_10: String port exits save address when usable
// RULE_11: Control-structure instructions fill instruction info
// RULE_12: I/O restart fields only on interrupt-after-I/O
// RULE_13: Natural-width fields saved full regardless mode; fast-call SP/IP upper halves are zeroed when ext64 is clear
// RULE_14: State saved as at exit start
// RULE_15: Save control, debug and fast-call registers
// RULE_16: State base kept except mgmt-mode exits
// RULE_17: Unusable code segment keeps base, limit, flags
// RULE_18: Unusable stack keeps privilege; bases upper zero
// RULE_19: Aux bases saved; local table base canonical
// RULE_20: Usable segments and table registers saved whole
// RULE_21: Access rights reserved bits cleared, bit16 unusable
// RULE_22: Undefined fields keep prior contents
//
// Local design decisions: the register offsets and the strobed register port.
`include "exit_save_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module exit_info_save
(
   input  wire logic                          ref_clk,
   input  wire logic                          arst_n,
   input  wire logic [`ES_ADDR_W-1:0]         reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic [31:0]                        reg_rdata,
   input  wire logic                          exit_req,
   input  wire exit_save_pkg::exit_cause_s    exit_cause,
   input  wire exit_save_pkg::ctl_arr_t       guest_ctl,
   input  wire exit_save_pkg::seg_arr_t       guest_seg,
   input  wire exit_save_pkg::desc_arr_t      guest_desc,
   output logic                               exit_taken
);
   import exit_save_pkg::*;

   //------------------------------------------------
   // Storage
   //------------------------------------------------
   logic [31:0] ctrl_reg;
   logic [15:0] count_reg;
   logic [31:0] vec_info_reg;
   logic [31:0] vec_err_reg;
   logic [31:0] instr_len_reg;
   logic [63:0] lin_reg;
   logic [31:0] vmx_info_reg;
   logic [31:0] smm_base_reg;
   logic [3:0][63:0] io_reg;
   ctl_arr_t    ctl_reg;
   seg_arr_t    seg_reg;
   desc_arr_t   desc_reg;

   logic        enable;
   logic        ext64;
   logic        take;
   logic        in_delivery;
   logic        len_used;

   assign enable = ctrl_reg[`ES_CTRL_ENABLE];
   assign ext64  = ctrl_reg[`ES_CTRL_EXT64];

   //------------------------------------------------
   // Exit qualification
   //------------------------------------------------
   // A task-gate exit is refused until the initial checks are good
   assign take = enable && exit_req
                 && !(exit_cause.task_gate && !exit_cause.task_checks_ok); // RULE_03

   assign in_delivery = (exit_cause.deliv_fault || exit_cause.task_gate) // RULE_01
                        && !exit_cause.direct_event                        // RULE_02
                        && !exit_cause.direct_dfault
                        && !exit_cause.handler_fetch
                        && !exit_cause.triple_fault;

   assign len_used = !exit_cause.trap_after_cr8                           // RULE_08
                     && (exit_cause.instr_fault_like                       // RULE_06
                         || exit_cause.breakpoint_or_overflow              // RULE_07
                         || exit_cause.exc_in_sw_delivery
                         || exit_cause.instr_task_switch);

   assign exit_taken = take;

   //------------------------------------------------
   // Segment conversion
   //------------------------------------------------
   function automatic seg_state_s seg_conv(
      input seg_state_s s,
      input seg_state_s old,
      input logic [2:0] idx,
      input logic       e64
   );
      seg_state_s r;
      r = old;
      r.unusable = s.unusable;
      if (!s.unusable)
      begin
         r.base  = s.base;                                                 // RULE_20
         r.limit = s.limit;
         r.ar[7:0]   = s.ar[7:0];
         r.ar[15:12] = s.ar[15:12];
      end
      else
      begin
         unique case (idx)
            `ES_SEG_CODE:
            begin
               r.base  = s.base;                                           // RULE_17
               r.limit = s.limit;
               r.ar[`ES_AR_LONG]  = s.ar[`ES_AR_LONG];
               r.ar[`ES_AR_DSIZE] = s.ar[`ES_AR_DSIZE];
               r.ar[`ES_AR_GRAN]  = s.ar[`ES_AR_GRAN];
            end
            `ES_SEG_STACK:
            begin
               r.ar[`ES_AR_DPL_LO+1:`ES_AR_DPL_LO] =
                  s.ar[`ES_AR_DPL_LO+1:`ES_AR_DPL_LO];                     // RULE_18
               if (e64)
                  r.base[63:32] = 32'h0000_0000;
            end
            `ES_SEG_DATA, `ES_SEG_EXTRA:
            begin
               if (e64)
                  r.base[63:32] = 32'h0000_0000;                           // RULE_18
            end
            `ES_SEG_AUX1, `ES_SEG_AUX2:
            begin
               r.base = s.base;                                            // RULE_19
            end
            `ES_SEG_LOCAL:
            begin
               r.base[63:`ES_CANON_BIT+1] =
                  {(63-`ES_CANON_BIT){old.base[`ES_CANON_BIT]}};           // RULE_19
            end
            default:
            begin
               r.base = old.base;                                          // RULE_22
            end
         endcase
      end
      r.ar[31:17] = 15'h0000;                                              // RULE_21
      r.ar[11:8]  = 4'h0;
      r.ar[`ES_AR_UNUSABLE] = s.unusable;
      return r;
   endfunction

   //------------------------------------------------
   // Control register
   //------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_reg <= `ES_CTRL_RESET;
      else if (reg_wr && reg_addr == `ES_OFF_CTRL)
         ctrl_reg <= {30'h0000_0000, reg_wdata[1:0]};
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         count_reg <= 16'h0000;
      else if (take)
         count_reg <= count_reg + 16'h0001;
   end

   //------------------------------------------------
   // Exit information fields
   //------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         vec_info_reg <= 32'h0000_0000;
         vec_err_reg  <= 32'h0000_0000;
      end
      else if (take)
      begin
         if (in_delivery)
         begin
            vec_info_reg <= exit_cause.deliv_info;                         // RULE_01
            vec_info_reg[`ES_INFO_VALID] <= 1'b1;
            if (exit_cause.deliv_info[`ES_INFO_ERR_VALID])
            begin
               vec_err_reg <= exit_cause.deliv_err;                        // RULE_05
               vec_err_reg[`ES_ERR_OUTSIDE] <= exit_cause.outside_origin_flag;
            end
         end
         else
            vec_info_reg[`ES_INFO_VALID] <= 1'b0;                          // RULE_04
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         instr_len_reg <= 32'h0000_0000;
      else if (take && len_used)
         instr_len_reg <= {28'h0000_000, exit_cause.instr_len};            // RULE_06
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         lin_reg <= 64'h0000_0000_0000_0000;
      else if (take && (exit_cause.load_machine_status_word_mem          // RULE_09
                        || (exit_cause.string_port_io
                            && exit_cause.string_seg_usable)))             // RULE_10
      begin
         lin_reg[31:0]  <= exit_cause.lin_addr[31:0];
         lin_reg[63:32] <= (ext64 && exit_cause.long_mode)
                           ? exit_cause.lin_addr[63:32] : 32'h0000_0000;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         vmx_info_reg <= 32'h0000_0000;
      else if (take && exit_cause.vmx_instr)
         vmx_info_reg <= exit_cause.vmx_info;                              // RULE_11
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         io_reg <= '0;
      else if (take && exit_cause.system_mgmt_mode_exit && exit_cause.mgmt_irq_after_io)
         io_reg <= exit_cause.io_restart;                                  // RULE_12
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         smm_base_reg <= 32'h0000_0000;
      else if (take && exit_cause.system_mgmt_mode_exit)
         smm_base_reg <= exit_cause.smm_state_base;                        // RULE_16
   end

   //------------------------------------------------
   // Guest state save, sampled in the exit cycle
   //------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         ctl_reg <= '0;
      else if (take)
      begin
         ctl_reg <= guest_ctl;                                             // RULE_15 RULE_14 RULE_13
         ctl_reg[`ES_CTL_SYSCALL_CS][63:32] <= 32'h0000_0000;
         if (!ext64)
         begin
            ctl_reg[`ES_CTL_SYSCALL_SP][63:32] <= 32'h0000_0000;
            ctl_reg[`ES_CTL_SYSCALL_IP][63:32] <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         desc_reg <= '0;
      else if (take)
         desc_reg <= guest_desc;                                           // RULE_20
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         seg_reg <= '0;
      else if (take)
      begin
         for (int i = 0; i < 8; i++)
            seg_reg[i] <= seg_conv(guest_seg[i], seg_reg[i], 3'(i), ext64); // RULE_14
      end
   end

   //------------------------------------------------
   // Register read port
   //------------------------------------------------
   function automatic logic [31:0] half(input logic [63:0] v, input logic hi);
      return hi ? v[63:32] : v[31:0];
   endfunction

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd)
      begin
         reg_rdata <= 32'h0000_0000;
         if (reg_addr >= `ES_OFF_SEG && reg_addr[9])
            reg_rdata <= 32'h0000_0000;
         else if (reg_addr >= `ES_OFF_SEG)
         begin
            unique case (reg_addr[3:2])
               2'h0: reg_rdata <= seg_reg[reg_addr[6:4]].base[31:0];
               2'h1: reg_rdata <= seg_reg[reg_addr[6:4]].base[63:32];
               2'h2: reg_rdata <= seg_reg[reg_addr[6:4]].limit;
               2'h3: reg_rdata <= seg_reg[reg_addr[6:4]].ar;
            endcase
         end
         else if (reg_addr >= `ES_OFF_DESC)
         begin
            if (reg_addr[5] == 1'b0 && reg_addr[3:2] != 2'h3)
               reg_rdata <= (reg_addr[3:2] == 2'h2) ? desc_reg[reg_addr[4]].limit
                            : half(desc_reg[reg_addr[4]].base, reg_addr[2]);
         end
         else if (reg_addr >= `ES_OFF_CTLREG)
            reg_rdata <= half(ctl_reg[reg_addr[5:3]], reg_addr[2]);
         else if (reg_addr >= `ES_OFF_IO_BASE)
         begin
            if (reg_addr[5] == 1'b0)
               reg_rdata <= half(io_reg[reg_addr[4:3]], reg_addr[2]);
         end
         else
         begin
            unique case (reg_addr)
               `ES_OFF_CTRL:      reg_rdata <= ctrl_reg;
               `ES_OFF_STATUS:    reg_rdata <= {16'h0000, count_reg};
               `ES_OFF_VEC_INFO:  reg_rdata <= vec_info_reg;
               `ES_OFF_VEC_ERR:   reg_rdata <= vec_err_reg;
               `ES_OFF_INSTR_LEN: reg_rdata <= instr_len_reg;
               `ES_OFF_LIN_LO:    reg_rdata <= lin_reg[31:0];
               `ES_OFF_LIN_HI:    reg_rdata <= lin_reg[63:32];
               `ES_OFF_VMX_INFO:  reg_rdata <= vmx_info_reg;
               `ES_OFF_SMM_BASE:  reg_rdata <= smm_base_reg;
               default:           reg_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ---- core/exit_save_consts.svh ----
// Register offsets, field positions, length limits and indices of the exit save block
`ifndef EXIT_SAVE_CONSTS_SVH
`define EXIT_SAVE_CONSTS_SVH

`define ES_ADDR_W         10
`define ES_OFF_CTRL       10'h000
`define ES_OFF_STATUS     10'h004
`define ES_OFF_VEC_INFO   10'h008
`define ES_OFF_VEC_ERR    10'h00C
`define ES_OFF_INSTR_LEN  10'h010
`define ES_OFF_LIN_LO     10'h014
`define ES_OFF_LIN_HI     10'h018
`define ES_OFF_VMX_INFO   10'h01C
`define ES_OFF_SMM_BASE   10'h020
`define ES_OFF_IO_BASE    10'h040
`define ES_OFF_CTLREG     10'h080
`define ES_OFF_DESC       10'h0C0
`define ES_OFF_SEG        10'h100

`define ES_CTRL_ENABLE    0
`define ES_CTRL_EXT64     1
`define ES_CTRL_RESET     32'h0000_0003

`define ES_INFO_VALID     31
`define ES_INFO_ERR_VALID 11
`define ES_ERR_OUTSIDE    0

`define ES_AR_UNUSABLE    16
`define ES_AR_DPL_LO      5
`define ES_AR_LONG        13
`define ES_AR_DSIZE       14
`define ES_AR_GRAN        15
`define ES_CANON_BIT      47

`define ES_LEN_MIN        4'h1
`define ES_LEN_MAX        4'hF

`define ES_SEG_CODE       3'h1
`define ES_SEG_STACK      3'h2
`define ES_SEG_DATA       3'h3
`define ES_SEG_EXTRA      3'h0
`define ES_SEG_AUX1       3'h4
`define ES_SEG_AUX2       3'h5
`define ES_SEG_LOCAL      3'h6

`define ES_CTL_SYSCALL_CS 3'h5
`define ES_CTL_SYSCALL_SP 3'h6
`define ES_CTL_SYSCALL_IP 3'h7

`endif

// ---- core/exit_save_pkg.sv ----
// Types shared by the exit save block and its users
package exit_save_pkg;

   typedef logic [63:0] word64_t;

   typedef struct packed {
      logic [63:0] base;
      logic [31:0] limit;
      logic [31:0] ar;
      logic        unusable;
   } seg_state_s;

   typedef struct packed {
      logic [63:0] base;
      logic [31:0] limit;
   } desc_state_s;

   typedef struct packed {
      logic        deliv_fault;
      logic        task_gate;
      logic        task_checks_ok;
      logic        direct_event;
      logic        direct_dfault;
      logic        handler_fetch;
      logic        triple_fault;
      logic [31:0] deliv_info;
      logic [31:0] deliv_err;
      logic        outside_origin_flag;
      logic        instr_fault_like;
      logic        breakpoint_or_overflow;
      logic        exc_in_sw_delivery;
      logic        instr_task_switch;
      logic        trap_after_cr8;
      logic [3:0]  instr_len;
      logic        load_machine_status_word_mem;
      logic        string_port_io;
      logic        string_seg_usable;
      logic        long_mode;
      logic [63:0] lin_addr;
      logic        vmx_instr;
      logic [31:0] vmx_info;
      logic        system_mgmt_mode_exit;
      logic        mgmt_irq_after_io;
      logic [3:0][63:0] io_restart;
      logic [31:0] smm_state_base;
   } exit_cause_s;

   typedef seg_state_s  [7:0] seg_arr_t;
   typedef desc_state_s [1:0] desc_arr_t;
   typedef word64_t     [7:0] ctl_arr_t;

endpackage

// ---- test/exit_info_save_chk.sv ----
// Concurrent checks on the exit save block ports
`include "exit_save_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module exit_info_save_chk
(
   input wire logic                      ref_clk,
   input wire logic                      arst_n,
   input wire logic [`ES_ADDR_W-1:0]     reg_addr,
   input wire logic [31:0]               reg_wdata,
   input wire logic                      reg_wr,
   input wire logic                      reg_rd,
   input wire logic [31:0]               reg_rdata,
   input wire logic                      exit_req,
   input wire exit_save_pkg::exit_cause_s exit_cause,
   input wire exit_save_pkg::ctl_arr_t   guest_ctl,
   input wire exit_save_pkg::seg_arr_t   guest_seg,
   input wire exit_save_pkg::desc_arr_t  guest_desc,
   input wire logic                      exit_taken
);
   import exit_save_pkg::*;
   // ------------------------------------------------------------
   // Shadow of the enable bit and of the last accepted exit
   // ------------------------------------------------------------
   logic        en_reg;
   exit_cause_s cq_reg;
   logic [31:0] ctl_reg;
   logic [31:0] lim_reg;
   logic        unu_reg;
   logic        refuse;
   logic        deliv;
   logic        len_case;
   logic        seen_reg;
   logic        dq_reg;
   logic        lq_reg;
   assign refuse = exit_cause.task_gate & ~exit_cause.task_checks_ok;
   assign deliv = (exit_cause.deliv_fault | (exit_cause.task_gate & exit_cause.task_checks_ok)) &
                  ~(exit_cause.direct_event | exit_cause.direct_dfault | exit_cause.handler_fetch |
                    exit_cause.triple_fault);
   assign len_case = (exit_cause.instr_fault_like | exit_cause.breakpoint_or_overflow |
                      exit_cause.exc_in_sw_delivery | exit_cause.instr_task_switch) & ~exit_cause.trap_after_cr8;
   always_ff @(posedge ref_clk or negedge arst_n)
      if (!arst_n)
         en_reg <= 1'b1;
      else if (reg_wr && reg_addr == `ES_OFF_CTRL)
         en_reg <= reg_wdata[`ES_CTRL_ENABLE];
   always_ff @(posedge ref_clk or negedge arst_n)
      if (!arst_n)
         seen_reg <= 1'b0;
      else if (exit_taken)
         seen_reg <= 1'b1;
   always_ff @(posedge ref_clk)
      if (exit_taken)
      begin
         cq_reg  <= exit_cause;
         dq_reg  <= deliv;
         lq_reg  <= len_case;
         ctl_reg <= guest_ctl[0][31:0];
         lim_reg <= guest_desc[0].limit;
         unu_reg <= guest_seg[0].unusable;
      end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_exit_rd(logic c, logic [`ES_ADDR_W-1:0] a);
      seen_reg && c && reg_rd && reg_addr == a && !exit_taken;
   endsequence
   a_take_accepted: assert property (exit_req && en_reg && !refuse |-> exit_taken)
      else $error("accepted exit not taken");
   a_take_cause: assert property (exit_taken |-> exit_req && en_reg && !refuse)
      else $error("exit taken without cause");
   a_vec_valid: assert property (s_exit_rd(dq_reg, `ES_OFF_VEC_INFO) |=> reg_rdata[31])
      else $error("vectoring valid bit clear");
   a_vec_invalid: assert property (s_exit_rd(!dq_reg, `ES_OFF_VEC_INFO) |=> !reg_rdata[31])
      else $error("vectoring valid bit set");
   a_err_code: assert property (s_exit_rd(dq_reg && cq_reg.deliv_info[11], `ES_OFF_VEC_ERR) |=>
      reg_rdata == {cq_reg.deliv_err[31:1], cq_reg.outside_origin_flag}) else $error("error code wrong");
   a_instr_len: assert property (s_exit_rd(lq_reg, `ES_OFF_INSTR_LEN) |=>
      reg_rdata[3:0] == cq_reg.instr_len) else $error("length wrong");
   a_ctl_saved: assert property (s_exit_rd(1'b1, `ES_OFF_CTLREG) |=> reg_rdata == ctl_reg)
      else $error("control register wrong");
   a_desc_limit: assert property (s_exit_rd(1'b1, `ES_OFF_DESC + 10'h008) |=> reg_rdata == lim_reg)
      else $error("table limit wrong");
   a_ar_clean: assert property (s_exit_rd(1'b1, `ES_OFF_SEG + 10'h00C) |=>
      reg_rdata[31:17] == 15'h0 && reg_rdata[11:8] == 4'h0 && reg_rdata[16] == unu_reg)
      else $error("access rights reserved bits wrong");
endmodule

bind exit_info_save exit_info_save_chk chk_i (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .exit_req, .exit_cause, .guest_ctl, .guest_seg, .guest_desc, .exit_taken);
`default_nettype wire

// ---- test/vm_exit_info_state_save_tb_top.sv ----
// Self-checking bench of the exit save block
`include "exit_save_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module vm_exit_info_state_save_tb_top;
   import exit_save_pkg::*;
   logic        ref_clk, arst_n, reg_wr, reg_rd, exit_req, exit_taken;
   logic [9:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   exit_cause_s cause;
   ctl_arr_t    ctl;
   seg_arr_t    seg;
   desc_arr_t   desc;
   int          error_cnt, n_compared, cnt;
   int          seed = 86;

   exit_info_save dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exit_req(exit_req), .exit_cause(cause),
      .guest_ctl(ctl), .guest_seg(seg), .guest_desc(desc), .exit_taken(exit_taken));

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // ------------------------------------------------------------
   // Bus, exit and compare tasks
   // ------------------------------------------------------------
   function automatic logic [1055:0] rb();
      for (int i = 0; i < 33; i++)
         rb[i*32+:32] = $random(seed);
   endfunction
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         error_cnt++;
      end
   endtask
   task automatic wr(logic [9:0] a, logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rc(string nm, logic [9:0] a, logic [31:0] m, logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(nm, reg_rdata & m, e & m);
   endtask
   task automatic do_exit(bit en, bit e64);
      exit_cause_s c; seg_arr_t s; ctl_arr_t g; desc_arr_t d;
      logic [1055:0] r; logic [31:0] b, hm; logic [9:0] a; bit tk, dl, u;
      r = rb(); c = r[$bits(exit_cause_s)-1:0]; b = r[1055:1024];
      c.direct_event = &b[1:0]; c.direct_dfault = &b[3:2]; c.handler_fetch = &b[5:4];
      c.triple_fault = &b[7:6]; c.task_checks_ok = |b[9:8]; c.instr_len = b[13:10] % 4'hF + 4'h1;
      r = rb(); s = r[$bits(seg_arr_t)-1:0];
      r = rb(); g = r[511:0]; d = r[703:512];
      @(posedge ref_clk);
      exit_req <= 1'b1; cause <= c; ctl <= g; seg <= s; desc <= d;
      tk = en && !(c.task_gate && !c.task_checks_ok);
      #1 chk("taken", exit_taken, tk);
      @(posedge ref_clk);
      exit_req <= 1'b0;
      cnt += tk;
      rc("count", `ES_OFF_STATUS, 32'h0000_FFFF, cnt);
      if (!tk)
         return;
      hm = e64 ? 32'hFFFF_FFFF : 32'h0;
      dl = (c.deliv_fault || (c.task_gate && c.task_checks_ok)) &&
           !(c.direct_event || c.direct_dfault || c.handler_fetch || c.triple_fault);
      rc("vinfo", `ES_OFF_VEC_INFO, dl ? 32'hFFFF_FFFF : 32'h8000_0000, {dl, c.deliv_info[30:0]});
      if (dl && c.deliv_info[11])
         rc("verr", `ES_OFF_VEC_ERR, 32'hFFFF_FFFF, {c.deliv_err[31:1], c.outside_origin_flag});
      if ((c.instr_fault_like || c.breakpoint_or_overflow || c.exc_in_sw_delivery || c.instr_task_switch) &&
          !c.trap_after_cr8)
         rc("len", `ES_OFF_INSTR_LEN, 32'hF, c.instr_len);
      if (c.load_machine_status_word_mem || (c.string_port_io && c.string_seg_usable))
      begin
         rc("lin_lo", `ES_OFF_LIN_LO, 32'hFFFF_FFFF, c.lin_addr[31:0]);
         rc("lin_hi", `ES_OFF_LIN_HI, 32'hFFFF_FFFF, c.long_mode && e64 ? c.lin_addr[63:32] : 32'h0);
      end
      if (c.vmx_instr)
         rc("vmx", `ES_OFF_VMX_INFO, 32'hFFFF_FFFF, c.vmx_info);
      if (c.system_mgmt_mode_exit)
         rc("smm_state_base", `ES_OFF_SMM_BASE, 32'hFFFF_FFFF, c.smm_state_base);
      for (int i = 0; i < 4; i++)
         if (c.system_mgmt_mode_exit && c.mgmt_irq_after_io)
            rc("io", `ES_OFF_IO_BASE + 10'(i * 8), 32'hFFFF_FFFF, c.io_restart[i][31:0]);
      for (int i = 0; i < 8; i++)
      begin
         rc("ctl_lo", `ES_OFF_CTLREG + 10'(i * 8), 32'hFFFF_FFFF, g[i][31:0]);
         if (i != 5)
            rc("ctl_hi", `ES_OFF_CTLREG + 10'(i * 8 + 4), hm, g[i][63:32]);
      end
      for (int i = 0; i < 2; i++)
      begin
         rc("dsc_lo", `ES_OFF_DESC + 10'(i * 16), 32'hFFFF_FFFF, d[i].base[31:0]);
         rc("dsc_hi", `ES_OFF_DESC + 10'(i * 16 + 4), hm, d[i].base[63:32]);
         rc("dsc_lim", `ES_OFF_DESC + 10'(i * 16 + 8), 32'hFFFF_FFFF, d[i].limit);
      end
      for (int i = 0; i < 8; i++)
      begin
         a = `ES_OFF_SEG + 10'(i * 16);
         u = s[i].unusable;
         rc("ar_rsv", a + 10'hC, 32'hFFFF_0F00, {15'h0, u, 16'h0});
         rc("ar", a + 10'hC, !u ? 32'hF0FF : i == `ES_SEG_CODE ? 32'hE000 : i == `ES_SEG_STACK ? 32'h60 : 32'h0,
            s[i].ar);
         if (!u || i == `ES_SEG_CODE || i == `ES_SEG_AUX1 || i == `ES_SEG_AUX2)
         begin
            rc("base_lo", a, 32'hFFFF_FFFF, s[i].base[31:0]);
            rc("base_hi", a + 10'h4, hm, s[i].base[63:32]);
         end
         if (!u || i == `ES_SEG_CODE)
            rc("limit", a + 10'h8, 32'hFFFF_FFFF, s[i].limit);
         if (u && (i == `ES_SEG_STACK || i == `ES_SEG_DATA || i == `ES_SEG_EXTRA))
            rc("base_z", a + 10'h4, hm, 32'h0);
         if (u && i == `ES_SEG_LOCAL && e64)
         begin
            @(posedge ref_clk);
            reg_rd <= 1'b1; reg_addr <= a + 10'h4;
            @(posedge ref_clk);
            reg_rd <= 1'b0;
            #1 chk("canon", reg_rdata[31:15] == 17'h0 || &reg_rdata[31:15], 1);
         end
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      error_cnt++;
      conclude();
   end
   initial
   begin
      arst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; exit_req = 1'b0; reg_addr = 10'h0; reg_wdata = 32'h0;
      cause = '0; ctl = '0; seg = '0; desc = '0;
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      rc("ctrl", `ES_OFF_CTRL, 32'hFFFF_FFFF, `ES_CTRL_RESET);
      rc("status", `ES_OFF_STATUS, 32'hFFFF_FFFF, 32'h0);
      wr(`ES_OFF_STATUS, 32'h0000_FFFF);
      rc("ro", `ES_OFF_STATUS, 32'hFFFF_FFFF, 32'h0);
      rc("unmapped", 10'h3FC, 32'hFFFF_FFFF, 32'h0);
      repeat (30) do_exit(1, 1);
      wr(`ES_OFF_CTRL, 32'h0000_0001);
      repeat (15) do_exit(1, 0);
      wr(`ES_OFF_CTRL, 32'h0000_0000);
      repeat (3) do_exit(0, 0);
      wr(`ES_OFF_CTRL, 32'h0000_0003);
      repeat (5) do_exit(1, 1);
      conclude();
   end
endmodule
`default_nettype wire
